// ===== csrg_top.sv
// chip-select and ready generator: area decode, wait states, control block registers
`timescale 1ns/1ps
`include "csrg_defines.svh"
module csrg_top
  import csrg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        cycle_start,
  input  csrg_cycle_t      cycle,
  input  wire logic        ext_ready,
  input  wire logic        coproc_busy,
  input  wire logic [1:0]  midrange_pin_in,
  output logic             ready_q,
  output logic             ctl_hit_q,
  output logic [15:0]      rdata_q,
  output logic             upper_memory_select_n_q,
  output logic             lower_memory_select_n_q,
  output logic [3:0]       midrange_memory_select_n_q,
  output logic [1:0]       midrange_pin_oe_n_q,
  output logic [6:0]       periph_select_n_q,
  output logic [1:0]       latched_addr_q,
  output logic             enhanced_q,
  output logic             coproc_extension_request_q,
  output logic             coproc_error_q
);
  typedef enum {ST_IDLE, ST_BUSY, ST_END} csrg_state_t;

  csrg_state_t state_q;
  // programmed state; each enable below stands for a first write of its area
  logic [15:0] upper_select_control_q;
  logic [15:0] lower_ctl_q;
  logic [15:0] per_ctl_q;
  logic [15:0] mid_base_q;
  logic [15:0] mid_size_q;
  logic [15:0] npx_q;
  logic [15:0] reloc_q;
  logic        lower_ok_q;
  logic        per_ok_q;
  logic        midb_ok_q;
  logic        mids_ok_q;
  logic        busy_low_q;
  logic        in_reset_q;

  // ready settings sit in the low three bits of the upper, lower, peripheral and mid base registers
  function automatic csrg_rdy_t rdy_of(input logic [15:0] c);
    rdy_of.ign_ext = c[`CSRG_F_IGN];
    rdy_of.waits   = c[`CSRG_F_WAIT_HI:0];
  endfunction

  // area start as a full 20-bit byte address, 1k granular
  function automatic logic [19:0] base_of(input logic [15:0] c);
    base_of = {c[15:`CSRG_F_BASE_LO], 10'h000};
  endfunction

  // 1k area number of a byte address, shared by the upper and lower compares
  function automatic logic [9:0] area_of(input logic [19:0] a);
    area_of = a[19:`CSRG_AREA_SHIFT];
  endfunction

  // ---------------- decode of the presented cycle ----------------
  logic        is_mem;
  logic        ctl_hit;
  logic        up_hit;
  logic        lo_hit;
  logic [19:0] mid_off;
  logic [4:0]  mid_bits;
  logic        mid_hit;
  logic [1:0]  mid_idx;
  logic [19:0] per_off;
  logic [2:0]  per_blk;
  logic        per_hit;
  logic        npx_hit;
  logic [3:0]  mid_vec;
  logic [6:0]  per_vec;
  csrg_rdy_t   rdy_sel;

  // dma and refresh cycles decode exactly like cpu cycles
  assign is_mem = ~cycle.io;
  // control block matched on the upper twelve address bits and its space
  assign ctl_hit = (cycle.addr[19:8] == reloc_q[11:0])
                   && (is_mem == reloc_q[`CSRG_F_RMEM]);
  assign up_hit = is_mem && (area_of(cycle.addr)
                  >= upper_select_control_q[15:`CSRG_F_BASE_LO]);
  assign lo_hit = is_mem && lower_ok_q && (area_of(cycle.addr)
                  <= lower_ctl_q[15:`CSRG_F_BASE_LO]);
  assign mid_off  = cycle.addr - base_of(mid_base_q);
  assign mid_bits = 5'(`CSRG_AREA_SHIFT) + {1'b0, mid_size_q[3:0]};
  // the block never overlaps upper or lower; those win if programmed so
  assign mid_hit = is_mem && midb_ok_q && mids_ok_q && !up_hit && !lo_hit
                   && ((mid_off >> mid_bits) == 20'h00000);
  // quarter index: top two offset bits inside the block
  assign mid_idx = 2'((mid_off >> (mid_bits - 5'h2)) & 20'h00003);
  assign per_off = cycle.addr - base_of(per_ctl_q);
  // 128-byte block number inside the 1k peripheral window
  assign per_blk = per_off[9:7];
  // seven 128-byte blocks; the eighth slot of the 1k window is not decoded
  assign per_hit = per_ok_q && (is_mem == per_ctl_q[`CSRG_F_PMEM])
                   && (per_off[19:10] == 10'h000)
                   && (per_blk != `CSRG_PER_BLOCKS);
  assign npx_hit = enhanced_q && cycle.io
                   && (cycle.addr[15:3] == npx_q[15:3]);

  // select vectors, with enhanced mode reassigning mid selects 0, 1 and 3
  always_comb begin
    mid_vec = 4'h0;
    per_vec = 7'h00;
    if (mid_hit) begin
      mid_vec[mid_idx] = 1'b1;
    end
    if (enhanced_q) begin
      mid_vec[0] = 1'b0;
      mid_vec[1] = 1'b0;
      mid_vec[3] = npx_hit;
    end
    if (per_hit) begin
      per_vec[per_blk] = 1'b1;
    end
  end

  // ready settings of the matched area; no match means external ready alone
  always_comb begin
    rdy_sel = '{ign_ext: 1'b0, waits: 2'h0};
    // the control block answers by itself, with no waits and no external ready
    if (ctl_hit) begin
      rdy_sel = '{ign_ext: 1'b1, waits: 2'h0};
    end else if (up_hit) begin
      rdy_sel = rdy_of(upper_select_control_q);
    end else if (lo_hit) begin
      rdy_sel = rdy_of(lower_ctl_q);
    end else if (mid_hit) begin
      rdy_sel = rdy_of(mid_base_q);
    end else if (per_hit) begin
      rdy_sel = rdy_of(per_ctl_q);
    end
  end

  // ---------------- cycle sequencing ----------------
  logic wait_done;
  logic take;

  // a request is taken only once the previous cycle has fully ended
  assign take = cycle_start && (state_q == ST_IDLE);

  // counting lives in its own module; each area only hands over its settings
  csrg_wait_gen u_wait (
    .clk       (clk),
    .reset     (reset),
    .start     (take),
    .cfg       (rdy_sel),
    .ext_ready (ext_ready),
    .done      (wait_done)
  );

  // selects hold from the start edge until the edge after the ready pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (cycle_start) begin
            state_q <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (wait_done) begin
            state_q <= ST_END;
          end
        end
        // one closing cycle lets the selects rise before a new start is taken
        ST_END: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // one-cycle ready pulse ends the bus cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= wait_done;
    end
  end

  // active-low selects latched at cycle start and held through the waits
  always_ff @(posedge clk) begin
    if (reset) begin
      upper_memory_select_n_q    <= 1'b1;
      lower_memory_select_n_q    <= 1'b1;
      midrange_memory_select_n_q <= 4'hf;
      periph_select_n_q          <= 7'h7f;
      ctl_hit_q                  <= 1'b0;
    end else if (take) begin
      upper_memory_select_n_q    <= ~(up_hit && !ctl_hit);
      lower_memory_select_n_q    <= ~(lo_hit && !ctl_hit);
      midrange_memory_select_n_q <= ctl_hit ? 4'hf : ~mid_vec;
      periph_select_n_q          <= ctl_hit ? 7'h7f : ~per_vec;
      ctl_hit_q                  <= ctl_hit;
    end else if (state_q == ST_END) begin
      upper_memory_select_n_q    <= 1'b1;
      lower_memory_select_n_q    <= 1'b1;
      midrange_memory_select_n_q <= 4'hf;
      periph_select_n_q          <= 7'h7f;
      ctl_hit_q                  <= 1'b0;
    end
  end

  // the option bit is undefined until the peripheral register is first written
  logic aout_en;
  assign aout_en = per_ok_q && per_ctl_q[`CSRG_F_AOUT];

  // address bits one and two held for slow peripherals when enabled
  always_ff @(posedge clk) begin
    if (reset) begin
      latched_addr_q <= 2'h0;
    end else if (take) begin
      latched_addr_q <= aout_en ? cycle.addr[2:1] : 2'h0;
    end
  end

  // ---------------- control block registers ----------------
  logic ctl_wr;
  logic ctl_rd;
  logic [7:0] ofs;

  // control accesses are decoded once, on the edge that takes the cycle
  assign ctl_wr = take && ctl_hit && cycle.write;
  assign ctl_rd = take && ctl_hit && !cycle.write;
  // byte bit zero is ignored: every register is a whole word
  assign ofs    = {cycle.addr[7:1], 1'b0};

  // upper area is live from reset on; the rest wait for a first write
  always_ff @(posedge clk) begin
    if (reset) begin
      upper_select_control_q <= `CSRG_UPPER_RST;
      reloc_q                <= `CSRG_RELOC_RST;
    end else if (ctl_wr) begin
      if (ofs == `CSRG_OFS_UPPER) begin
        upper_select_control_q <= cycle.wdata;
      end
      // low twelve bits give address bits 19..8, bit twelve picks memory space
      if (ofs == `CSRG_OFS_RELOC) begin
        reloc_q <= cycle.wdata;
      end
    end
  end

  // contents undefined after reset, so only the enables are cleared
  always_ff @(posedge clk) begin
    if (reset) begin
      lower_ok_q <= 1'b0;
      per_ok_q   <= 1'b0;
      midb_ok_q  <= 1'b0;
      mids_ok_q  <= 1'b0;
    end else if (ctl_wr) begin
      lower_ok_q <= lower_ok_q || (ofs == `CSRG_OFS_LOWER);
      per_ok_q   <= per_ok_q || (ofs == `CSRG_OFS_PERIPH);
      midb_ok_q  <= midb_ok_q || (ofs == `CSRG_OFS_MIDBASE);
      mids_ok_q  <= mids_ok_q || (ofs == `CSRG_OFS_MIDSIZE);
    end
  end

  // data registers carry no reset: the enables above keep them harmless
  always_ff @(posedge clk) begin
    if (ctl_wr) begin
      if (ofs == `CSRG_OFS_LOWER) begin
        lower_ctl_q <= cycle.wdata;
      end
      if (ofs == `CSRG_OFS_PERIPH) begin
        per_ctl_q <= cycle.wdata;
      end
      if (ofs == `CSRG_OFS_MIDBASE) begin
        mid_base_q <= cycle.wdata;
      end
      if (ofs == `CSRG_OFS_MIDSIZE) begin
        mid_size_q <= cycle.wdata;
      end
    end
  end

  // coprocessor port register exists only in enhanced mode
  always_ff @(posedge clk) begin
    if (reset) begin
      npx_q <= `CSRG_NPX_RST;
    end else if (ctl_wr && enhanced_q && ofs == `CSRG_OFS_NPX) begin
      npx_q <= cycle.wdata;
    end
  end

  // read data; unmapped offsets and hidden enhanced registers read zero
  // the word is captured on the taking edge and stands until the next read
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 16'h0000;
    end else if (ctl_rd) begin
      unique case (ofs)
        `CSRG_OFS_UPPER:   rdata_q <= upper_select_control_q;
        `CSRG_OFS_LOWER:   rdata_q <= lower_ctl_q;
        `CSRG_OFS_PERIPH:  rdata_q <= per_ctl_q;
        `CSRG_OFS_MIDBASE: rdata_q <= mid_base_q;
        `CSRG_OFS_MIDSIZE: rdata_q <= mid_size_q;
        `CSRG_OFS_NPX:     rdata_q <= enhanced_q ? npx_q : 16'h0000;
        `CSRG_OFS_RELOC:   rdata_q <= reloc_q;
        default:           rdata_q <= 16'h0000;
      endcase
    end
  end

  // ---------------- operating mode ----------------
  // busy low on the last reset edge and high on release selects enhanced mode;
  // only the last edge counts, so an unknown level early in reset is forgotten
  always_ff @(posedge clk) begin
    in_reset_q <= reset;
    if (reset) begin
      busy_low_q <= !coproc_busy;
    end
  end

  // strap verdict, looked at only on the first edge after release
  logic strap_enh;
  assign strap_enh = busy_low_q && coproc_busy;

  // mode and mid pin direction turn together, so no pin is driven against an input
  always_ff @(posedge clk) begin
    if (reset) begin
      enhanced_q          <= 1'b0;
      midrange_pin_oe_n_q <= 2'h0;
    end else if (in_reset_q) begin
      enhanced_q          <= strap_enh;
      midrange_pin_oe_n_q <= {2{strap_enh}};
    end
  end

  // in enhanced mode mid pins 0 and 1 are coprocessor inputs; error is active low
  always_ff @(posedge clk) begin
    if (reset) begin
      coproc_extension_request_q <= 1'b0;
      coproc_error_q             <= 1'b0;
    end else begin
      coproc_extension_request_q <= enhanced_q && midrange_pin_in[0];
      coproc_error_q             <= enhanced_q && !midrange_pin_in[1];
    end
  end
endmodule

// ===== csrg_defines.svh
// register offsets, field positions, reset values and counts of the chip-select block
// Notes on behaviour
// - registers are 16 bits in a relocatable 256-byte block answered internally
// - selects assert for cpu and dma cycles alike in their area
// - latched address bits one and two may be driven out
// - six memory selects: one upper, one lower, four mid-range
// - upper area ends at the top of memory, holding the reset start
// - lower area starts at address zero, holding the vector table
// - mid-range block has programmable base and size outside upper and lower
// - seven peripheral selects cover seven 128-byte blocks above a base
// - peripheral base lies in memory or i/o space, matching only that space
// - each area inserts zero to three programmed wait states
// - per area, external ready is ignored or combined with internal ready
// - all selects are high while reset is applied
// - upper control resets to 1k block, three waits plus external ready
// - other areas stay inactive until their control registers are written
// - enhanced mode turns mid selects 0,1,3 into coprocessor signals
// - mid select two covers one quarter of the block with its ready settings
// - refresh reads inside a programmed area assert that select
// - in compatible mode enhanced registers ignore writes and read zero
// - enhanced mode follows from the coprocessor busy strap
`ifndef CSRG_DEFINES_SVH
`define CSRG_DEFINES_SVH
`define CSRG_OFS_UPPER   8'ha0
`define CSRG_OFS_LOWER   8'ha2
`define CSRG_OFS_PERIPH  8'ha4
`define CSRG_OFS_MIDBASE 8'ha6
`define CSRG_OFS_MIDSIZE 8'ha8
`define CSRG_OFS_NPX     8'haa
`define CSRG_OFS_RELOC   8'hfe
`define CSRG_UPPER_RST   16'hfffb
`define CSRG_RELOC_RST   16'h00ff
`define CSRG_NPX_RST     16'h00f8
`define CSRG_F_IGN       2
`define CSRG_F_WAIT_HI   1
`define CSRG_F_BASE_LO   6
`define CSRG_F_PMEM      5
`define CSRG_F_AOUT      3
`define CSRG_F_RMEM      12
`define CSRG_PER_BLOCKS  3'h7
`define CSRG_AREA_SHIFT  10
`endif

// ===== csrg_pkg.sv
// types shared by the chip-select and ready generator
package csrg_pkg;
  typedef enum logic [1:0] {CSRG_CPU, CSRG_DMA, CSRG_REFRESH} csrg_kind_t;
  typedef struct packed {
    logic [19:0] addr;
    logic        io;
    logic        write;
    csrg_kind_t  kind;
    logic [15:0] wdata;
  } csrg_cycle_t;
  typedef struct packed {
    logic       ign_ext;
    logic [1:0] waits;
  } csrg_rdy_t;
endpackage

// ===== csrg_wait_gen.sv
// wait-state counter that ends a bus cycle from programmed waits and external ready
`timescale 1ns/1ps
module csrg_wait_gen
  import csrg_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      reset,
  input  wire logic      start,
  input  csrg_rdy_t      cfg,
  input  wire logic      ext_ready,
  output logic           done
);
  logic       busy_q;
  logic [1:0] cnt_q;
  logic       ign_q;

  // load the count at cycle start, then count down once per clock
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_q <= 1'b0;
      cnt_q  <= 2'h0;
      ign_q  <= 1'b0;
    end else if (start) begin
      busy_q <= 1'b1;
      cnt_q  <= cfg.waits;
      ign_q  <= cfg.ign_ext;
    end else if (busy_q) begin
      if (cnt_q != 2'h0) begin
        cnt_q <= cnt_q - 2'h1;
      end else if (done) begin
        busy_q <= 1'b0;
      end
    end
  end

  // external ready only counts once the internal waits have run out
  assign done = busy_q && (cnt_q == 2'h0) && (ign_q || ext_ready);
endmodule

// ===== csrg_monitor.sv
// port-level assertions for the chip-select and ready generator
`timescale 1ns/1ps
module csrg_monitor (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       ready_q,
  input wire logic       ctl_hit_q,
  input wire logic       upper_memory_select_n_q,
  input wire logic       lower_memory_select_n_q,
  input wire logic [3:0] midrange_memory_select_n_q,
  input wire logic [6:0] periph_select_n_q,
  input wire logic [1:0] midrange_pin_in,
  input wire logic [1:0] midrange_pin_oe_n_q,
  input wire logic       enhanced_q,
  input wire logic       coproc_extension_request_q,
  input wire logic       coproc_error_q
);
  logic [12:0] sel_n;
  // every select side by side, all high means no area hit
  assign sel_n = {upper_memory_select_n_q, lower_memory_select_n_q,
                  midrange_memory_select_n_q, periph_select_n_q};
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_rst_idle;
    $fell(reset) |-> &sel_n && !ready_q && !enhanced_q;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("active output after reset");
  property p_pulse;
    ready_q |=> !ready_q;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_hold;
    sel_n != 13'h1fff && !ready_q |=> $stable(sel_n);
  endproperty
  a_hold: assert property (p_hold) else $error("select moved inside cycle");
  property p_release;
    ready_q && sel_n != 13'h1fff |=> &sel_n;
  endproperty
  a_release: assert property (p_release) else $error("select kept after ready");
  // reset value of the upper area gives three waits before any ready
  property p_upper_wait;
    $fell(upper_memory_select_n_q) |-> !ready_q [*4] ##[0:600] ready_q;
  endproperty
  a_upper_wait: assert property (p_upper_wait) else $error("upper wait count");
  property p_one_sel;
    $onehot0(~sel_n);
  endproperty
  a_one_sel: assert property (p_one_sel) else $error("two selects at once");
  property p_ctl_quiet;
    ctl_hit_q |-> &sel_n;
  endproperty
  a_ctl_quiet: assert property (p_ctl_quiet) else $error("select on control access");
  property p_enh_pins;
    enhanced_q |-> midrange_pin_oe_n_q == 2'b11 && midrange_memory_select_n_q[1:0] == 2'b11;
  endproperty
  a_enh_pins: assert property (p_enh_pins) else $error("mid pins driven in enhanced");
  property p_req_copy;
    enhanced_q && $past(enhanced_q) |-> coproc_extension_request_q == $past(midrange_pin_in[0])
      && coproc_error_q == !$past(midrange_pin_in[1]);
  endproperty
  a_req_copy: assert property (p_req_copy) else $error("coprocessor pins not followed");
  property p_compat;
    !enhanced_q |-> midrange_pin_oe_n_q == 2'b00 && !coproc_extension_request_q
      && !coproc_error_q;
  endproperty
  a_compat: assert property (p_compat) else $error("enhanced role in compatible");
endmodule

// ===== csrg_far_model.sv
// far side: memories answer ready after a stall, coprocessor pins and busy strap
`timescale 1ns/1ps
module csrg_far_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       cycle_start,
  input  wire logic       ready_q,
  input  wire logic [7:0] stall,
  input  wire logic       enh_req,
  output logic            ext_ready,
  output logic            coproc_busy,
  output logic [1:0]      midrange_pin_in
);
  logic       act_q = 1'b0;
  logic [7:0] cnt_q = 8'h00;
  logic [1:0] pin_q = 2'h0;
  // a slow device holds ready low until its stall count has run
  always_ff @(posedge clk) begin
    if (reset || ready_q) act_q <= 1'b0;
    else if (cycle_start) act_q <= 1'b1;
    cnt_q <= cycle_start ? 8'h00 : cnt_q + 8'h01;
  end
  assign ext_ready = act_q && (cnt_q >= stall);
  // strap low only inside reset, released high afterwards
  assign coproc_busy = !(enh_req && reset);
  // request pin changes every cycle and error pin every second cycle, so stale copies show
  always_ff @(posedge clk) pin_q <= pin_q + 2'h1;
  assign midrange_pin_in = pin_q;
endmodule

// ===== test_chip_select_ready_generator.sv
// self-checking bench of the chip-select and ready generator
`timescale 1ns/1ps
`include "csrg_defines.svh"
module test_chip_select_ready_generator import csrg_pkg::*;;
  logic clk, reset, cycle_start, ext_ready, coproc_busy, enh_req, ready_q, ctl_hit_q;
  logic upper_memory_select_n_q, lower_memory_select_n_q, enhanced_q;
  logic coproc_extension_request_q, coproc_error_q;
  csrg_cycle_t cycle;
  logic [15:0] rdata_q, rd;
  logic [3:0]  midrange_memory_select_n_q;
  logic [6:0]  periph_select_n_q;
  logic [1:0]  midrange_pin_in, midrange_pin_oe_n_q, latched_addr_q, la;
  logic [7:0]  stall;
  logic [12:0] sel;
  logic [19:0] a;
  int n_mismatch, checked, tick, lat, w, ign, k, q;
  csrg_top u_dut (.clk, .reset, .cycle_start, .cycle, .ext_ready, .coproc_busy,
    .midrange_pin_in, .ready_q, .ctl_hit_q, .rdata_q, .upper_memory_select_n_q,
    .lower_memory_select_n_q, .midrange_memory_select_n_q, .midrange_pin_oe_n_q,
    .periph_select_n_q, .latched_addr_q, .enhanced_q, .coproc_extension_request_q,
    .coproc_error_q);
  csrg_far_model u_far (.clk, .reset, .cycle_start, .ready_q, .stall, .enh_req,
    .ext_ready, .coproc_busy, .midrange_pin_in);
  // 250 MHz clock
  always #2 clk = ~clk;
  // hang guard, far beyond the few hundred cycles the run takes
  always @(posedge clk) begin
    tick++;
    if (tick == 8000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic summarize;
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // expected select vector with one bit low, 13 gives all high
  function automatic logic [12:0] selx(input int b);
    return 13'h1fff ^ (13'h1 << b);
  endfunction
  // one bus cycle: start for one edge, sample selects, wait for ready
  task automatic bus(input logic [19:0] ad, input logic io, input logic wr,
                     input logic [15:0] wd, input csrg_kind_t kd);
    cycle = '{addr: ad, io: io, write: wr, kind: kd, wdata: wd};
    cycle_start = 1'b1;
    @(posedge clk);
    #1 cycle_start = 1'b0;
    sel = {upper_memory_select_n_q, lower_memory_select_n_q,
           midrange_memory_select_n_q, periph_select_n_q};
    la = latched_addr_q;
    lat = 0;
    while (ready_q !== 1'b1 && lat < 600) begin
      @(posedge clk);
      #1 lat++;
    end
    rd = rdata_q;
    @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] o, input logic [15:0] v);
    bus({12'h0ff, o}, 1'b1, 1'b1, v, CSRG_CPU);
  endtask
  task automatic rreg(input logic [7:0] o);
    bus({12'h0ff, o}, 1'b1, 1'b0, 16'h0000, CSRG_CPU);
  endtask
  // reset pulse with strap chosen by enh_req
  task automatic do_reset;
    reset = 1'b1;
    repeat (8) @(posedge clk);
    #1 reset = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic mid_setup;
    wreg(`CSRG_OFS_MIDBASE, 16'h403e);
    wreg(`CSRG_OFS_MIDSIZE, 16'h0002);
  endtask
  initial begin
    clk = 1'b0;
    cycle_start = 1'b0;
    cycle = '0;
    stall = 8'h00;
    enh_req = 1'b0;
    void'($urandom(76660));
    do_reset();
    rreg(`CSRG_OFS_UPPER);
    chk("upper_ctl", rd, `CSRG_UPPER_RST);
    wreg(`CSRG_OFS_NPX, 16'h1234);
    rreg(`CSRG_OFS_NPX);
    chk("npx_compat", rd, 16'h0000);
    bus(20'hffff0, 1'b0, 1'b0, 16'h0000, CSRG_CPU);
    chk("upper_sel", sel, selx(12));
    chk("upper_lat", lat, 4);
    // nothing programmed here yet: only the slow external ready ends it
    stall = 8'h03;
    bus(20'h10000 + 20'($urandom % 20'h80000), 1'b0, 1'b0, 16'h0000, CSRG_DMA);
    chk("none_sel", sel, selx(13));
    chk("none_lat", lat > 3, 1);
    // lower area, random waits and ready mode, every cycle kind
    for (k = 0; k < 6; k++) begin
      w = $urandom % 4;
      ign = $urandom % 2;
      stall = 8'(w + 2 + $urandom % 3);
      wreg(`CSRG_OFS_LOWER, 16'h0038 | 16'(ign * 4 + w));
      bus(20'($urandom % 1024), 1'b0, 1'b0, 16'h0000, csrg_kind_t'(k % 3));
      chk("lower_sel", sel, selx(11));
      if (ign != 0) chk("lower_lat", lat, w + 1);
      else chk("lower_ext", lat > stall, 1);
    end
    bus(20'h00010, 1'b1, 1'b0, 16'h0000, CSRG_CPU);
    chk("lower_io", sel, selx(13));
    // peripheral blocks at 0x800 in each space; the other space must miss
    stall = 8'h00;
    for (q = 0; q < 2; q++) begin
      wreg(`CSRG_OFS_PERIPH, 16'h008a | 16'(q * 32));
      for (k = 0; k < 8; k++) begin
        a = 20'h00800 + 20'(k * 128) + 20'($urandom % 64 * 2);
        bus(a, q == 0, 1'b0, 16'h0000, CSRG_CPU);
        chk("per_sel", sel, selx(k < 7 ? k : 13));
        if (k < 7) chk("per_addr", la, a[2:1]);
        if (k < 7) chk("per_lat", lat, 3);
        bus(a, q != 0, 1'b0, 16'h0000, CSRG_CPU);
        chk("per_space", sel, selx(13));
      end
    end
    // 4k mid block at 0x40000, one select per quarter
    mid_setup();
    for (k = 0; k < 4; k++) begin
      bus(20'h40000 + 20'(k * 1024 + $urandom % 1024), 1'b0, 1'b0, 16'h0000, CSRG_CPU);
      chk("mid_sel", sel, selx(7 + k));
      chk("mid_lat", lat, 3);
    end
    // strap low in reset picks enhanced mode
    enh_req = 1'b1;
    do_reset();
    chk("enh", enhanced_q, 1);
    rreg(`CSRG_OFS_NPX);
    chk("npx_rst", rd, `CSRG_NPX_RST);
    mid_setup();
    for (k = 0; k < 4; k++) begin
      bus(20'h40000 + 20'(k * 1024 + $urandom % 1024), 1'b0, 1'b0, 16'h0000, CSRG_CPU);
      chk("enh_mid", sel, selx(k == 2 ? 9 : 13));
    end
    bus({4'h0, `CSRG_NPX_RST}, 1'b1, 1'b0, 16'h0000, CSRG_CPU);
    chk("npx_sel", sel, selx(10));
    summarize();
  end
endmodule
bind csrg_top csrg_monitor u_mon (.clk, .reset, .ready_q, .ctl_hit_q,
  .upper_memory_select_n_q, .lower_memory_select_n_q, .midrange_memory_select_n_q,
  .periph_select_n_q, .midrange_pin_in, .midrange_pin_oe_n_q, .enhanced_q,
  .coproc_extension_request_q, .coproc_error_q);
